// ===== verilog/rpc_pkg.sv
// Shared constants for the receive per-channel indirect controller
package rpc_pkg;
  // Device register offsets on the byte port
  localparam logic [7:0] REG_CONFIG = 8'h50;
  localparam logic [7:0] REG_STATUS = 8'h51;
  localparam logic [7:0] REG_ADDR_CTRL = 8'h52;
  localparam logic [7:0] REG_DATA_BUF = 8'h53;
  // Field positions
  localparam int CFG_IND_BIT = 1;
  localparam int CFG_PER_CHANNEL_FUNC_ENABLE_BIT = 0;
  localparam int STAT_BUSY_BIT = 7;
  localparam int AC_DIR_BIT = 7;
  localparam int CTL_INVERT_BIT = 7;
  localparam int CTL_DCOND_BIT = 6;
  localparam int CTL_MW_BIT = 5;
  localparam int CTL_MSB_FLIP_BIT = 4;
  localparam int SIG_SUB_BIT = 7;
  // Writable bits of the table bytes
  localparam logic [7:0] CTL_MASK = 8'hF0;
  localparam logic [7:0] DCOND_MASK = 8'hFF;
  localparam logic [7:0] SIG_MASK = 8'h8F;
  // Reset values
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [7:0] AC_RESET = 8'h00;
  localparam logic [7:0] DB_RESET = 8'h00;
  // Internal table layout
  localparam int NUM_CHAN = 24;
  localparam int TABLE_SIZE = 72;
  localparam logic [6:0] IDX_CTRL_FIRST = 7'h01;
  localparam logic [6:0] IDX_DCOND_FIRST = 7'h19;
  localparam logic [6:0] IDX_SCOND_FIRST = 7'h31;
  localparam logic [6:0] IDX_LAST = 7'h48;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACCESS_MAX_NS = 640;
  localparam int ACCESS_MAX_CYC = ACCESS_MAX_NS / CLK_PERIOD_NS;
  localparam int ACCESS_LAT_CYC = 4;
  // Host controller registers on Wishbone
  localparam logic [3:0] HC_REG_CMD = 4'h0;
  localparam logic [3:0] HC_REG_STAT = 4'h4;
  localparam int HC_CMD_DATA_LSB = 0;
  localparam int HC_CMD_IDX_LSB = 8;
  localparam int HC_CMD_KIND_LSB = 16;
  localparam int HC_STAT_BUSY_BIT = 0;
  localparam int HC_STAT_DONE_BIT = 1;
  localparam int HC_STAT_RD_LSB = 8;
  // Host command kinds
  typedef enum logic [1:0] {
    KIND_CFG = 2'b00,
    KIND_WR = 2'b01,
    KIND_RD = 2'b10
  } rpc_kind_type;
endpackage

// ===== verilog/rpc_if.sv
// Byte register port joining the host controller to the device
`timescale 1ns/1ps
interface rpc_if;
  logic req;
  logic we;
  logic [7:0] adr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic ack;
  modport dev (input req, input we, input adr, input wdat, output rdat, output ack);
  modport host (output req, output we, output adr, output wdat, input rdat, input ack);
endinterface

// ===== verilog/rpc_dev.sv
// Device end: indirect table, access sequencer, stream conditioning and FIFO
// Operation
// [R1] Indirect select bit, cleared by reset
// [R2] Enable bit gates all per-channel functions
// [R3] Busy bit 7 high during access
// [R4] Host polls busy before next request
// [R5] Access finishes within 640 ns
// [R6] Address/control write starts one access
// [R7] Bit 7 one reads, zero writes
// [R8] Host loads data buffer before write
// [R9] Read byte lands in buffer within 640 ns
// [R10] Indices 01H-18H hold control bytes
// [R11] Indices 19H-30H hold data conditioning bytes
// [R12] Indices 31H-48H hold signalling conditioning bytes
// [R13] Two control bits select inversion kind
// [R14] Milliwatt beats substitution beats inversion
// [R15] Data substitution sends stored byte
// [R16] Signalling substitution puts stored nibble low
// [R17] Busy rises the cycle after acceptance
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

module rpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic ready_r;
  logic push;
  logic pop;

  assign push = i_in_valid && ready_r;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_valid = (count_r != '0);
  assign o_out_data = mem_r[rd_ptr_r];
  assign o_in_ready = ready_r;

  // Occupancy after this cycle's push and pop
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Pointers, count and registered ready
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != CW'(DEPTH));
    end
  end

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end
endmodule // rpc_fifo

module rpc_dev #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [63:0] MW_PATTERN = 64'h0000000000000000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  rpc_if.dev bus,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [7:0] i_in_pcm,
  input wire logic [3:0] i_in_sig,
  input wire logic [4:0] i_in_chan,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [7:0] o_out_pcm,
  output logic [7:0] o_out_sig,
  output logic [4:0] o_out_chan
);
  localparam int FW = 17;
  logic ack_r;
  logic [7:0] rdat_r;
  logic ind_sel_r;
  logic pcc_en_r;
  logic busy_r;
  logic [4:0] cnt_r;
  logic [7:0] addr_ctrl_r;
  logic [7:0] data_buf_r;
  logic [7:0] tbl_r [rpc_pkg::TABLE_SIZE];
  logic wr_hit;
  logic start;
  logic finish;
  logic idx_ok;
  logic [6:0] idx;
  logic [7:0] wmask;
  logic f_valid;
  logic f_pop;
  logic [FW-1:0] f_data;
  logic [2:0] mw_phase_r;
  logic out_valid_r;
  logic [7:0] out_pcm_r;
  logic [7:0] out_sig_r;
  logic [4:0] out_chan_r;
  logic [7:0] pcm_nxt;
  logic [7:0] sig_nxt;
  logic [7:0] ctl;
  logic [7:0] dcond;
  logic [7:0] scond;
  logic [4:0] f_chan;

  assign wr_hit = bus.req && !ack_r && bus.we;
  assign idx = addr_ctrl_r[6:0];
  assign idx_ok = (bus.wdat[6:0] >= rpc_pkg::IDX_CTRL_FIRST) && (bus.wdat[6:0] <= rpc_pkg::IDX_LAST);
  // [R6] Valid index write starts access
  assign start = wr_hit && (bus.adr == rpc_pkg::REG_ADDR_CTRL) && !busy_r && ind_sel_r && idx_ok;
  // [R5] Fixed latency well inside limit
  assign finish = busy_r && (cnt_r == 5'(rpc_pkg::ACCESS_LAT_CYC - 1));
  assign bus.ack = ack_r;
  assign bus.rdat = rdat_r;

  // Register port: one-cycle acknowledge with registered read data
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      ack_r <= bus.req && !ack_r;
      rdat_r <= 8'h00;
      if (bus.req && !ack_r && !bus.we) begin
        if (bus.adr == rpc_pkg::REG_CONFIG) begin
          rdat_r <= {6'h00, ind_sel_r, pcc_en_r};
        end else if (bus.adr == rpc_pkg::REG_STATUS) begin
          rdat_r <= {busy_r, 7'h00};
        end else if (bus.adr == rpc_pkg::REG_ADDR_CTRL) begin
          rdat_r <= addr_ctrl_r;
        end else if (bus.adr == rpc_pkg::REG_DATA_BUF) begin
          rdat_r <= data_buf_r;
        end
      end
    end
  end

  // Configuration bits
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      // [R1] Reset disables indirect mode
      {ind_sel_r, pcc_en_r} <= rpc_pkg::CFG_RESET;
    end else if (wr_hit && (bus.adr == rpc_pkg::REG_CONFIG)) begin
      ind_sel_r <= bus.wdat[rpc_pkg::CFG_IND_BIT];
      pcc_en_r <= bus.wdat[rpc_pkg::CFG_PER_CHANNEL_FUNC_ENABLE_BIT];
    end
  end

  // Address/control register and access sequencer
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      addr_ctrl_r <= rpc_pkg::AC_RESET;
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
    end else begin
      if (wr_hit && (bus.adr == rpc_pkg::REG_ADDR_CTRL) && !busy_r) begin
        addr_ctrl_r <= bus.wdat;
      end
      if (start) begin
        // [R17] Busy visible next cycle
        busy_r <= 1'b1;
        cnt_r <= 5'h00;
      end else if (finish) begin
        // [R3] Busy drops once done
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // Data buffer: host writes when idle, indirect reads fill it
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      data_buf_r <= rpc_pkg::DB_RESET;
    end else if (finish && addr_ctrl_r[rpc_pkg::AC_DIR_BIT]) begin
      // [R9] Read result into buffer
      data_buf_r <= tbl_r[idx - 7'd1];
    end else if (wr_hit && (bus.adr == rpc_pkg::REG_DATA_BUF) && !busy_r) begin
      // [R8] Buffer loaded ahead of write
      data_buf_r <= bus.wdat;
    end
  end

  // Writable bits by table region
  always_comb begin
    if (idx < rpc_pkg::IDX_DCOND_FIRST) begin
      wmask = rpc_pkg::CTL_MASK;
    end else if (idx < rpc_pkg::IDX_SCOND_FIRST) begin
      wmask = rpc_pkg::DCOND_MASK;
    end else begin
      wmask = rpc_pkg::SIG_MASK;
    end
  end

  // Internal table, cleared by reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int i = 0; i < rpc_pkg::TABLE_SIZE; i++) begin
        tbl_r[i] <= 8'h00;
      end
    end else if (finish && !addr_ctrl_r[rpc_pkg::AC_DIR_BIT]) begin
      // [R7] Direction zero writes entry
      tbl_r[idx - 7'd1] <= data_buf_r & wmask;
    end
  end

  rpc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_in_valid),
    .o_in_ready(o_in_ready),
    .i_in_data({i_in_chan, i_in_sig, i_in_pcm}),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_data)
  );

  assign f_chan = f_data[16:12];
  assign f_pop = f_valid && (!out_valid_r || i_out_ready);

  // Per-channel lookup and conditioning of the byte at the FIFO head
  always_comb begin
    ctl = 8'h00;
    dcond = 8'h00;
    scond = 8'h00;
    pcm_nxt = f_data[7:0];
    sig_nxt = {4'h0, f_data[11:8]};
    if (int'(f_chan) < rpc_pkg::NUM_CHAN) begin
      // [R10] Control bytes first
      ctl = tbl_r[int'(f_chan)];
      // [R11] Data conditioning bytes next
      dcond = tbl_r[int'(f_chan) + rpc_pkg::NUM_CHAN];
      // [R12] Signalling bytes last
      scond = tbl_r[int'(f_chan) + 2 * rpc_pkg::NUM_CHAN];
    end
    // [R2] Functions only when enabled
    if (pcc_en_r) begin
      // [R14] Milliwatt, then substitution, then inversion
      if (ctl[rpc_pkg::CTL_MW_BIT]) begin
        pcm_nxt = MW_PATTERN[63 - 8 * int'(mw_phase_r) -: 8];
      end else if (ctl[rpc_pkg::CTL_DCOND_BIT]) begin
        // [R15] Stored byte sent in place of the input byte
        pcm_nxt = dcond;
      end else begin
        // [R13] Invert all, msb only, or magnitude
        case ({ctl[rpc_pkg::CTL_INVERT_BIT], ctl[rpc_pkg::CTL_MSB_FLIP_BIT]})
          2'b10: pcm_nxt = ~f_data[7:0];
          2'b01: pcm_nxt = f_data[7:0] ^ 8'h80;
          2'b11: pcm_nxt = f_data[7:0] ^ 8'h7F;
          default: pcm_nxt = f_data[7:0];
        endcase
      end
      // [R16] Stored nibble replaces signalling
      if (scond[rpc_pkg::SIG_SUB_BIT]) begin
        sig_nxt = {4'h0, scond[3:0]};
      end
    end
  end

  // Output stage and milliwatt phase, advanced after the last channel
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      out_valid_r <= 1'b0;
      out_pcm_r <= 8'h00;
      out_sig_r <= 8'h00;
      out_chan_r <= 5'h00;
      mw_phase_r <= 3'h0;
    end else begin
      if (f_pop) begin
        out_valid_r <= 1'b1;
        out_pcm_r <= pcm_nxt;
        out_sig_r <= sig_nxt;
        out_chan_r <= f_chan;
        if (int'(f_chan) == rpc_pkg::NUM_CHAN - 1) begin
          mw_phase_r <= mw_phase_r + 3'h1;
        end
      end else if (i_out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

  assign o_out_valid = out_valid_r;
  assign o_out_pcm = out_pcm_r;
  assign o_out_sig = out_sig_r;
  assign o_out_chan = out_chan_r;
endmodule // rpc_dev

// ===== verilog/rpc_host.sv
// Host end: Wishbone command registers driving indirect accesses
`timescale 1ns/1ps
module rpc_host (
  input wire logic i_clk,
  input wire logic i_resetn,
  rpc_if.host bus,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CFG = 3'b001,
    H_POLL_A = 3'b010,
    H_WR_DATA = 3'b011,
    H_WR_ADDR = 3'b100,
    H_POLL_B = 3'b101,
    H_RD_DATA = 3'b110
  } rpc_hstate_type;

  rpc_hstate_type state_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic wb_hit;
  logic cmd_go;
  logic done_r;
  logic [7:0] rd_byte_r;
  logic [7:0] cmd_data_r;
  logic [6:0] cmd_idx_r;
  rpc_pkg::rpc_kind_type cmd_kind_r;
  logic req_r;
  logic we_r;
  logic [7:0] adr_r;
  logic [7:0] wdat_r;
  logic op_end;

  assign wb_hit = i_wb_cyc && i_wb_stb && !wb_ack_r;
  assign cmd_go = wb_hit && i_wb_we && (i_wb_adr == rpc_pkg::HC_REG_CMD) && (i_wb_sel[2:0] == 3'h7)
                  && (state_r == H_IDLE);
  assign bus.req = req_r;
  assign bus.we = we_r;
  assign bus.adr = adr_r;
  assign bus.wdat = wdat_r;
  assign o_wb_ack = wb_ack_r;
  assign o_wb_dat = wb_dat_r;

  // Wishbone slave: acknowledge one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack_r <= wb_hit;
      wb_dat_r <= 32'h00000000;
      if (wb_hit && !i_wb_we && (i_wb_adr == rpc_pkg::HC_REG_STAT)) begin
        wb_dat_r[rpc_pkg::HC_STAT_BUSY_BIT] <= (state_r != H_IDLE);
        wb_dat_r[rpc_pkg::HC_STAT_DONE_BIT] <= done_r;
        wb_dat_r[rpc_pkg::HC_STAT_RD_LSB +: 8] <= rd_byte_r;
      end
    end
  end

  // Latched command fields
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cmd_data_r <= 8'h00;
      cmd_idx_r <= 7'h00;
      cmd_kind_r <= rpc_pkg::KIND_CFG;
    end else if (cmd_go) begin
      cmd_data_r <= i_wb_dat[rpc_pkg::HC_CMD_DATA_LSB +: 8];
      cmd_idx_r <= i_wb_dat[rpc_pkg::HC_CMD_IDX_LSB +: 7];
      cmd_kind_r <= rpc_pkg::rpc_kind_type'(i_wb_dat[rpc_pkg::HC_CMD_KIND_LSB +: 2]);
    end
  end

  // Completion flag and read result; a finish wins over a new start
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      done_r <= 1'b0;
      rd_byte_r <= 8'h00;
    end else begin
      if (op_end) begin
        done_r <= 1'b1;
      end else if (cmd_go) begin
        done_r <= 1'b0;
      end
      if ((state_r == H_RD_DATA) && req_r && bus.ack) begin
        rd_byte_r <= bus.rdat;
      end
    end
  end

  assign op_end = req_r && bus.ack && ((state_r == H_CFG) || (state_r == H_RD_DATA)
                  || ((state_r == H_POLL_B) && !bus.rdat[rpc_pkg::STAT_BUSY_BIT]
                      && (cmd_kind_r == rpc_pkg::KIND_WR)));

  // Sequencer: one byte transfer per state, request held until acknowledge
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_r <= H_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      adr_r <= 8'h00;
      wdat_r <= 8'h00;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (cmd_go) begin
            if (rpc_pkg::rpc_kind_type'(i_wb_dat[rpc_pkg::HC_CMD_KIND_LSB +: 2]) == rpc_pkg::KIND_CFG) begin
              state_r <= H_CFG;
            end else begin
              state_r <= H_POLL_A;
            end
          end
        end
        H_CFG: begin
          if (!req_r) begin
            // [R1] Software sets indirect select here
            {req_r, we_r, adr_r, wdat_r} <= {1'b1, 1'b1, rpc_pkg::REG_CONFIG, cmd_data_r};
          end else if (bus.ack) begin
            req_r <= 1'b0;
            state_r <= H_IDLE;
          end
        end
        H_POLL_A, H_POLL_B: begin
          if (!req_r) begin
            // [R4] Poll busy before proceeding
            {req_r, we_r, adr_r} <= {1'b1, 1'b0, rpc_pkg::REG_STATUS};
          end else if (bus.ack) begin
            req_r <= 1'b0;
            if (!bus.rdat[rpc_pkg::STAT_BUSY_BIT]) begin
              if (state_r == H_POLL_B) begin
                state_r <= (cmd_kind_r == rpc_pkg::KIND_RD) ? H_RD_DATA : H_IDLE;
              end else begin
                state_r <= (cmd_kind_r == rpc_pkg::KIND_WR) ? H_WR_DATA : H_WR_ADDR;
              end
            end
          end
        end
        H_WR_DATA: begin
          if (!req_r) begin
            // [R8] Data buffer first for writes
            {req_r, we_r, adr_r, wdat_r} <= {1'b1, 1'b1, rpc_pkg::REG_DATA_BUF, cmd_data_r};
          end else if (bus.ack) begin
            req_r <= 1'b0;
            state_r <= H_WR_ADDR;
          end
        end
        H_WR_ADDR: begin
          if (!req_r) begin
            // [R7] Direction bit from command kind
            {req_r, we_r, adr_r} <= {1'b1, 1'b1, rpc_pkg::REG_ADDR_CTRL};
            wdat_r <= {(cmd_kind_r == rpc_pkg::KIND_RD), cmd_idx_r};
          end else if (bus.ack) begin
            req_r <= 1'b0;
            state_r <= H_POLL_B;
          end
        end
        H_RD_DATA: begin
          if (!req_r) begin
            // [R9] Fetch byte once busy clears
            {req_r, we_r, adr_r} <= {1'b1, 1'b0, rpc_pkg::REG_DATA_BUF};
          end else if (bus.ack) begin
            req_r <= 1'b0;
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
          req_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // rpc_host

// ===== tb/rpc_assertions.sv
// Protocol checker for the host-to-device byte register port
`timescale 1ns/1ps
module rpc_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [7:0] wdat,
  input wire logic [7:0] rdat,
  input wire logic ack
);
  localparam int BUSY_MAX = rpc_pkg::ACCESS_MAX_CYC;
  logic ind_r;
  logic [5:0] since_r;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Shadow of the indirect select bit written by the host
  always_ff @(posedge i_clk) begin
    if (!i_resetn) ind_r <= 1'b0;
    else if (req && !ack && we && adr == rpc_pkg::REG_CONFIG) ind_r <= wdat[rpc_pkg::CFG_IND_BIT];
  end
  // Cycles since the last address/control write, saturating
  always_ff @(posedge i_clk) begin
    if (!i_resetn) since_r <= 6'h3F;
    else if (req && !ack && we && adr == rpc_pkg::REG_ADDR_CTRL) since_r <= 6'h00;
    else if (since_r != 6'h3F) since_r <= since_r + 6'h01;
  end
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  ack_follow_a: assert property (req && !ack |=> ack) else $error("request not answered");
  ack_cause_a: assert property (ack |-> $past(req)) else $error("ack without request");
  rdat_idle_a: assert property (!ack |-> rdat == 8'h00) else $error("read data outside ack");
  req_hold_a: assert property (req && !ack |=> req && $stable(adr) && $stable(we) && $stable(wdat))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req) else $error("request kept after ack");
  adr_map_a: assert property (req |-> adr inside {[8'h50:8'h53]}) else $error("request off the map");
  stat_bits_a: assert property (ack && !$past(we) && $past(adr) == rpc_pkg::REG_STATUS
    |-> rdat[6:0] == 7'h00) else $error("status spare bits set");
  busy_bound_a: assert property (ack && !$past(we) && $past(adr) == rpc_pkg::REG_STATUS && rdat[7]
    |-> since_r <= BUSY_MAX) else $error("busy too long or unprompted");
  ind_gate_a: assert property (ack && !$past(we) && $past(adr) == rpc_pkg::REG_STATUS && !ind_r
    |-> !rdat[rpc_pkg::STAT_BUSY_BIT]) else $error("access started with indirect select off");
  // Main scenarios
  cover property (ack && $past(we) && $past(adr) == rpc_pkg::REG_ADDR_CTRL);
  cover property (ack && $past(adr) == rpc_pkg::REG_STATUS && rdat[7]);
  cover property (ack && !$past(we) && $past(adr) == rpc_pkg::REG_DATA_BUF);
endmodule // rpc_assertions

// ===== tb/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_resetn, wb_cyc, wb_stb, wb_we, wb_ack, in_valid, in_ready, out_valid, out_ready, stall, en_m;
  logic [3:0] wb_adr, wb_sel, in_sig;
  logic [31:0] wb_dat, wb_rdat, r;
  logic [7:0] in_pcm, out_pcm, out_sig, d;
  logic [4:0] in_chan, out_chan;
  logic [7:0] tbl [0:72];
  logic [20:0] exp_q [$];
  int errors, total_checks, ph;
  localparam logic [63:0] MW = 64'h0123456789ABCDEF;
  rpc_if bus_if ();
  rpc_host rpc_host_inst (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_if), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_sel(wb_sel),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack));
  rpc_dev #(.FIFO_DEPTH(4), .MW_PATTERN(MW)) rpc_dev_inst (.i_clk(i_clk), .i_resetn(i_resetn),
    .bus(bus_if), .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_pcm(in_pcm), .i_in_sig(in_sig),
    .i_in_chan(in_chan), .o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_pcm(out_pcm),
    .o_out_sig(out_sig), .o_out_chan(out_chan));
  rpc_assertions rpc_assertions_inst (.i_clk(i_clk), .i_resetn(i_resetn), .req(bus_if.req),
    .we(bus_if.we), .adr(bus_if.adr), .wdat(bus_if.wdat), .rdat(bus_if.rdat), .ack(bus_if.ack));
  // Clock at 40 MHz
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One classic Wishbone cycle, result in r
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dat);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= dat;
    wb_sel <= 4'hF;
    @(posedge i_clk);
    while (wb_ack !== 1'b1) @(posedge i_clk);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask
  // Poll controller status until idle
  task automatic poll;
    r = 32'h1;
    while (r[0] !== 1'b0) wb(1'b0, rpc_pkg::HC_REG_STAT, 32'h0);
  endtask
  task automatic cmd(input rpc_pkg::rpc_kind_type k, input logic [6:0] idx, input logic [7:0] dat);
    poll();
    wb(1'b1, rpc_pkg::HC_REG_CMD, {14'h0, k, 1'b0, idx, dat});
    poll();
  endtask
  // Expected stream output from the table model
  function automatic logic [20:0] model(input logic [4:0] c, input logic [7:0] p, input logic [3:0] s);
    logic [7:0] ct, po, so, sc;
    po = p;
    so = {4'h0, s};
    if (en_m && c < 5'd24) begin
      ct = tbl[c + 1];
      sc = tbl[c + 49];
      if (ct[5]) po = MW[63 - 8 * ph -: 8];
      else if (ct[6]) po = tbl[c + 25];
      else po = p ^ {ct[7] ^ ct[4], {7{ct[7]}}};
      if (sc[7]) so = {4'h0, sc[3:0]};
    end
    if (c == 5'd23) ph = (ph + 1) % 8;
    return {c, so, po};
  endfunction
  // Offer one byte, held until taken
  task automatic send(input logic [4:0] c, input logic [7:0] p, input logic [3:0] s);
    in_valid <= 1'b1;
    in_chan <= c;
    in_pcm <= p;
    in_sig <= s;
    @(posedge i_clk);
    while (in_ready !== 1'b1) @(posedge i_clk);
    exp_q.push_back(model(c, p, s));
  endtask
  task automatic run(input int cnt);
    int k;
    for (int i = 0; i < cnt; i++) send(5'(i % 25), 8'($urandom), 4'($urandom));
    in_valid <= 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    check("drained", exp_q.size(), 0);
  endtask
  // Sink with random stalls
  always @(posedge i_clk) out_ready <= !stall && ($urandom % 4 != 0);
  // Compare every delivered byte
  always @(posedge i_clk) begin
    if (i_resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      // Conditioning result against the model
      check("stream", {out_chan,out_sig,out_pcm}, exp_q.size() ? exp_q.pop_front() : 21'h1FFFFF);
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    test_done();
  end
  initial begin
    {i_resetn, wb_cyc, wb_stb, wb_we, in_valid, stall, en_m} = 7'h00;
    {wb_adr, wb_sel, in_sig, in_chan, in_pcm, wb_dat} = '0;
    errors = 0;
    total_checks = 0;
    ph = 0;
    for (int i = 0; i <= 72; i++) tbl[i] = 8'h00;
    void'($urandom(32'h2c12));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    wb(1'b0, rpc_pkg::HC_REG_STAT, 32'h0);
    check("status reset", r, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    check("unmapped", r, 32'h0);
    wb(1'b0, rpc_pkg::HC_REG_CMD, 32'h0);
    check("cmd read", r, 32'h0);
    $display("test reset done");
    cmd(rpc_pkg::KIND_CFG, 7'h00, 8'h01);
    cmd(rpc_pkg::KIND_WR, 7'h01, 8'hF0);
    cmd(rpc_pkg::KIND_CFG, 7'h00, 8'h03);
    cmd(rpc_pkg::KIND_RD, 7'h01, 8'h00);
    check("refused write", r[15:8], 8'h00);
    $display("test select done");
    for (int i = 1; i <= 72; i++) begin
      d = 8'($urandom) & (i <= 24 ? rpc_pkg::CTL_MASK : i <= 48 ? rpc_pkg::DCOND_MASK : rpc_pkg::SIG_MASK);
      cmd(rpc_pkg::KIND_WR, i[6:0], d);
      tbl[i] = d;
    end
    for (int i = 1; i <= 72; i++) begin
      cmd(rpc_pkg::KIND_RD, i[6:0], 8'h00);
      check("table", {r[15:8], r[1:0]}, {tbl[i], 2'b10});
    end
    $display("test table done");
    cmd(rpc_pkg::KIND_CFG, 7'h00, 8'h02);
    run(10);
    $display("test bypass done");
    cmd(rpc_pkg::KIND_CFG, 7'h00, 8'h03);
    en_m = 1'b1;
    stall <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 5; i++) send(5'(i + 19), 8'($urandom), 4'($urandom));
    in_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    check("fifo full", in_ready, 0);
    stall <= 1'b0;
    run(60);
    $display("test stream done");
    test_done();
  end
endmodule // testbench
